/* File: ddr_cmd_addr_decode_data_place_tb_top.sv */
`timescale 1ns/1ps
`include "ddrc_params.svh"
`define CHK(g, x) begin \
    tests_run++; \
    if ((g) !== (x)) begin \
        mismatches++; \
        $display("wrong value at %0t: got %h exp %h", $time, g, x); \
    end \
end

module ddr_cmd_addr_decode_data_place_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata, rv, a, w;
    logic awready, wready, bvalid, arready, rvalid, ck, cs_n, strobe_pin, dq_oe, st_out, st_oe;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] dq_pin, dq_dev;
    logic [15:0] mem [16];
    logic [15:0] cfg = `DDRC_CFG_RST;
    logic [15:0] ew;
    logic [47:0] h;
    logic [63:0] rows [8];
    int mismatches = 0, tests_run = 0, cycles = 0, nb;

    always #5 clk = ~clk;

    ddrc_cmd_decode u_ddrc_cmd_decode (
        .core_clk_in(clk), .reset_in(rst), .link_ck_in(ck), .cs_n_in(cs_n),
        .dq_in(dq_pin), .dq_out(dq_dev), .dq_oe_out(dq_oe), .rw_data_strobe_in(strobe_pin),
        .rw_data_strobe_out(st_out), .rw_data_strobe_oe_out(st_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    ddrc_host_model u_host (
        .core_clk_in(clk), .dev_dq_in(dq_dev), .dev_dq_oe_in(dq_oe), .dev_strobe_in(st_out),
        .dev_strobe_oe_in(st_oe), .link_ck_out(ck), .cs_n_out(cs_n), .dq_out(dq_pin),
        .strobe_out(strobe_pin));

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // bus write, each channel released once taken
    task automatic axw(input logic [11:0] ad, input logic [31:0] d, output logic [1:0] r);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axr(input logic [11:0] ad, output logic [31:0] d, output logic [1:0] r);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        // header, byte count, data seed; all eight rows used
        rows = '{64'h2000_0000_0000_2010, 64'h0000_0000_fffe_0880, 64'ha000_0000_0006_0800,
            64'h8000_0001_0006_0800, 64'h4000_0000_0001_025a, 64'hc000_0000_0000_0400,
            64'h2000_0000_0002_03c0, 64'ha000_0000_0002_0400};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axw(12'h000, 32'h0000_0011, rsp);
        `CHK(rsp, `DDRC_RESP_OKAY)
        axr(12'h000, rv, rsp);
        `CHK(rv, 32'h0000_0011)
        // one frame per row against a shadow of the array
        for (int k = 0; k < 8; k++) begin
            h = rows[k][63:16];
            nb = rows[k][15:8];
            a = {h[44:16], h[2:0]}; // reserved bits dropped
            for (int i = 0; i < 16; i++) begin
                u_host.wd[i] = {rows[k][7:0] + 8'(i), ~(rows[k][7:0] + 8'(i))};
            end
            u_host.frame(h, nb, 1);
            for (int i = 0; i < nb / 2; i++) begin
                w = h[45] ? a + i : {a[31:3], 3'(a[2:0] + i)};
                ew = h[46] ? ((w == 0) ? `DDRC_ID_VALUE : cfg) : mem[w[3:0]];
                if (!h[47] && h[46] && w == 1) cfg = u_host.wd[i];
                else if (!h[47] && !h[46]) mem[w[3:0]] = u_host.wd[i];
                else if (h[47]) `CHK(u_host.rd[i], ew)
            end
            if (h[47]) `CHK(u_host.rsb, 32'h5555_5555 & ((32'h1 << nb) - 1))
        end
        axr(12'h008, rv, rsp);
        `CHK(rv, 32'h0000_0004)
        axr(12'h010, rv, rsp);
        `CHK({rv, rsp}, {32'h0, `DDRC_RESP_SLVERR})
        axw(12'h010, 32'h0, rsp);
        `CHK(rsp, `DDRC_RESP_SLVERR)
        // second reset mid run
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK({dq_oe, st_oe}, 2'h0)
        rst <= 1'b0;
        @(posedge clk);
        axr(12'h000, rv, rsp);
        `CHK(rv, {24'h0, `DDRC_CTRL_RST})
        conclude();
    end
endmodule

/* File: ddrc_axil.sv */
`timescale 1ns/1ps
`include "ddrc_params.svh"

// axi4-lite slave holding control and reading back block state
module ddrc_axil #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] status_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] link_in,
    output ddrc_pkg::ddrc_ctrl_s ctrl_out
);

    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] ctrl_reg;
    logic [8:0] w_hold;
    logic [ADDR_W-3:0] aw_idx;
    logic [ADDR_W-3:0] ar_idx;

    assign aw_idx = aw_addr[ADDR_W-1:2];
    assign ar_idx = s_axi_araddr[ADDR_W-1:2];
    assign ctrl_out.enable = ctrl_reg[`DDRC_CTRL_EN_BIT];
    assign ctrl_out.lat_clks = ctrl_reg[`DDRC_CTRL_LAT_MSB:`DDRC_CTRL_LAT_LSB];

    // write channels taken in either order, answer after both
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DDRC_RESP_OKAY;
            aw_addr <= '0;
            ctrl_reg <= `DDRC_CTRL_RST;
            w_hold <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_hold <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
            end
            // both taken: held byte lands in ctrl_reg only when the taken address is the control index
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                if (aw_idx == (ADDR_W-2)'(`DDRC_IDX_CTRL) && w_hold[8]) begin
                    ctrl_reg <= w_hold[7:0];
                end
                s_axi_bresp <= (aw_idx < `DDRC_MAP_TOP) ? `DDRC_RESP_OKAY : `DDRC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel, one outstanding
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `DDRC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `DDRC_RESP_OKAY;
            if (ar_idx == ADDR_W'(`DDRC_IDX_CTRL)) begin
                s_axi_rdata <= {24'h000000, ctrl_reg};
            end else if (ar_idx == ADDR_W'(`DDRC_IDX_STATUS)) begin
                s_axi_rdata <= status_in;
            end else if (ar_idx == ADDR_W'(`DDRC_IDX_ADDR)) begin
                s_axi_rdata <= addr_in;
            end else if (ar_idx == ADDR_W'(`DDRC_IDX_LINK)) begin
                s_axi_rdata <= link_in;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= `DDRC_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

/* File: ddrc_cmd_decode.sv */
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "ddrc_params.svh"

// What this block does
// R1 - header bit 47 high means read, low means write
// R2 - header bit 46 picks memory array (0) or register space (1)
// R3 - header bit 45 picks wrapped (0) or linear (1) burst
// R4 - header bits 44..16 give word address bits 31..3
// R5 - host zeroes upper row bits unused by the density
// R6 - header bits 15..3 reserved, ignored here, host drives zero
// R7 - header bits 2..0 give word address bits 2..0, burst start word
// R8 - upper column picks 8-word half-page, lower column the start word
// R9 - initial latency timing starts once row and upper column are captured
// R10 - linear read bursts run on across consecutive half-pages
// R11 - on reads the strobe is driven, data edge-aligned to it
// R12 - data moves in whole 16-bit words only
// R13 - word address advances once per clock cycle in data phase
// R14 - first byte from strobe rise to fall, second from fall to rise
// R15 - byte bit 7 on lane 7 down to bit 0 on lane 0
// R16 - memory returns each byte in the position it was written
// R17 - register words big-endian: bits 15..8 first, 7..0 second
// R18 - each decoded address names one 16-bit word
// R19 - chip select falls with clock idle, header on first six edges
// R20 - strobe always signals doubled latency in header, doubled applied
// R21 - decoded direction, space and burst act only after six edges
module ddrc_cmd_decode #(
    parameter int ADDR_W = 12,
    parameter int MEM_WORDS = 16
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic link_ck_in,
    input wire logic cs_n_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_out,
    input wire logic rw_data_strobe_in,
    output logic rw_data_strobe_out,
    output logic rw_data_strobe_oe_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int IDX_W = $clog2(MEM_WORDS);

    // ************************************************************
    // pin sampling
    // ************************************************************
    ddrc_pkg::ddrc_pins_s pins_raw;
    ddrc_pkg::ddrc_pins_s pins;
    ddrc_pkg::ddrc_ctrl_s ctrl;
    ddrc_pkg::ddrc_state_e state;
    ddrc_pkg::ddrc_hdr_s hdr;
    ddrc_pkg::ddrc_hdr_s next_hdr;
    logic ck_prev;
    logic cs_prev;
    logic ck_edge;
    logic ck_rise;
    logic cs_fall;
    logic start;
    logic hdr_done;
    logic [2:0] edge_cnt;
    logic [39:0] hdr_sr;
    logic lat_run;
    logic [6:0] lat_cnt;
    logic [6:0] lat_target;
    logic lat_done;
    logic [31:0] word_addr;
    logic [31:0] next_addr;
    logic [IDX_W-1:0] mem_idx;
    logic [15:0] mem [MEM_WORDS];
    logic [15:0] rd_word;
    logic [15:0] link_cfg;
    logic [7:0] byte_a;
    logic mask_a;
    logic wr_word;
    logic [15:0] txn_cnt;

    assign pins_raw = '{ck: link_ck_in, cs_n: cs_n_in, strobe: rw_data_strobe_in, dq: dq_in};

    ddrc_sync #(
        .W($bits(ddrc_pkg::ddrc_pins_s)),
        .RST_VAL(11'h200)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    // previous levels for edge finding
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ck_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            ck_prev <= pins.ck;
            cs_prev <= pins.cs_n;
        end
    end

    // both clock edges carry a byte
    assign ck_edge = pins.ck ^ ck_prev;
    assign ck_rise = pins.ck & ~ck_prev;
    assign cs_fall = ~pins.cs_n & cs_prev;

    // ************************************************************
    // register bus
    // ************************************************************
    ddrc_axil #(
        .ADDR_W(ADDR_W)
    ) u_axil (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .status_in({24'h000000, 2'h0, state, hdr.dir, hdr.space_select_bit,
            hdr.burst_linear, lat_run}),
        .addr_in(word_addr),
        .link_in({link_cfg, txn_cnt}),
        .ctrl_out(ctrl)
    );

    // ************************************************************
    // header capture and decode
    // ************************************************************
    assign start = (state == ddrc_pkg::ST_IDLE) && cs_fall && !pins.ck && ctrl.enable; // [R19]
    assign hdr_done = (state == ddrc_pkg::ST_HDR) && ck_edge
        && (edge_cnt == `DDRC_HDR_LAST_EDGE); // [R19]
    assign next_hdr = {hdr_sr, pins.dq}; // [R15] [R19]

    // transaction phase
    always_ff @(posedge core_clk_in) begin
        if (reset_in || pins.cs_n) begin
            state <= ddrc_pkg::ST_IDLE;
        end else begin
            unique case (state)
                ddrc_pkg::ST_IDLE: begin
                    if (start) begin
                        state <= ddrc_pkg::ST_HDR;
                    end
                end
                ddrc_pkg::ST_HDR: begin
                    if (hdr_done) begin
                        state <= ddrc_pkg::ST_LAT; // [R21]
                    end
                end
                ddrc_pkg::ST_LAT: begin
                    if (lat_done) begin
                        state <= ddrc_pkg::ST_DATA;
                    end
                end
                ddrc_pkg::ST_DATA: begin
                    state <= ddrc_pkg::ST_DATA;
                end
            endcase
        end
    end

    // shift in header bytes, highest first
    always_ff @(posedge core_clk_in) begin
        if (reset_in || start) begin
            edge_cnt <= 3'h0;
            hdr_sr <= '0;
        end else if ((state == ddrc_pkg::ST_HDR) && ck_edge) begin
            edge_cnt <= edge_cnt + 3'h1;
            hdr_sr <= next_hdr[39:0]; // [R19]
        end
    end

    // decoded fields held only once the header is whole
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            hdr <= '0;
            txn_cnt <= 16'h0000;
        end else if (hdr_done) begin
            hdr <= next_hdr; // [R1] [R2] [R3] [R6] [R21]
            txn_cnt <= txn_cnt + 16'h0001;
        end
    end

    // ************************************************************
    // initial latency
    // ************************************************************
    // doubled latency in edges plus the two header edges left
    assign lat_target = {1'b0, ctrl.lat_clks, 2'b00} + `DDRC_LAT_PAD; // [R20]
    assign lat_done = (state == ddrc_pkg::ST_LAT) && ck_edge && (lat_cnt + 7'h01 == lat_target);

    // counting starts at the edge that completes the row address
    always_ff @(posedge core_clk_in) begin
        if (reset_in || pins.cs_n) begin
            lat_run <= 1'b0;
            lat_cnt <= 7'h00;
        end else if ((state == ddrc_pkg::ST_HDR) && ck_edge
            && (edge_cnt == `DDRC_ROWCAP_EDGE)) begin
            lat_run <= 1'b1; // [R9]
            lat_cnt <= 7'h00;
        end else if (lat_done) begin
            lat_run <= 1'b0;
        end else if (lat_run && ck_edge) begin
            lat_cnt <= lat_cnt + 7'h01;
        end
    end

    // ************************************************************
    // word addressing
    // ************************************************************
    // linear runs on across half-pages, wrapped stays in eight words
    always_comb begin
        if (hdr.burst_linear) begin
            next_addr = word_addr + 32'h0000_0001; // [R10] [R13]
        end else begin
            next_addr = {word_addr[31:`DDRC_HALF_PAGE_MSB+1],
                word_addr[`DDRC_HALF_PAGE_MSB:0] + 3'h1}; // [R3] [R8]
        end
    end

    // header address is a word address, advanced after byte two
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            word_addr <= 32'h0000_0000;
        end else if (hdr_done) begin
            word_addr <= {next_hdr.row_ucol, next_hdr.lcol}; // [R4] [R7] [R8] [R18]
        end else if ((state == ddrc_pkg::ST_DATA) && ck_edge && !ck_rise) begin
            word_addr <= next_addr; // [R13]
        end
    end

    assign mem_idx = word_addr[IDX_W-1:0];

    // register space returns id or config word
    always_comb begin
        if (!hdr.space_select_bit) begin
            rd_word = mem[mem_idx]; // [R2] [R16]
        end else if (word_addr == `DDRC_LREG_ID) begin
            rd_word = `DDRC_ID_VALUE; // arbitrary identity value
        end else begin
            rd_word = link_cfg;
        end
    end

    // ************************************************************
    // write data capture
    // ************************************************************
    // byte one held until byte two completes the word
    always_ff @(posedge core_clk_in) begin
        if (reset_in || start) begin
            byte_a <= 8'h00;
            mask_a <= 1'b1;
        end else if ((state == ddrc_pkg::ST_DATA) && !hdr.dir && ck_rise) begin
            byte_a <= pins.dq; // [R14]
            mask_a <= pins.strobe;
        end
    end

    // a lone first byte is dropped when chip select rises
    assign wr_word = (state == ddrc_pkg::ST_DATA) && !hdr.dir && ck_edge && !ck_rise; // [R12]

    // storage entries, each byte kept where it was written
    for (genvar g = 0; g < MEM_WORDS; g++) begin : g_mem
        always_ff @(posedge core_clk_in) begin
            if (wr_word && !hdr.space_select_bit && (mem_idx == IDX_W'(g))) begin
                if (!mask_a) begin
                    mem[g][15:8] <= byte_a; // [R16]
                end
                if (!pins.strobe) begin
                    mem[g][7:0] <= pins.dq; // [R16]
                end
            end
        end
    end

    // config word written big-endian, mask not applied to registers
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            link_cfg <= `DDRC_CFG_RST;
        end else if (wr_word && hdr.space_select_bit && (word_addr == `DDRC_LREG_CFG)) begin
            link_cfg <= {byte_a, pins.dq}; // [R17]
        end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    // strobe high in header marks doubled latency, then read strobe
    always_ff @(posedge core_clk_in) begin
        if (reset_in || pins.cs_n) begin
            rw_data_strobe_oe_out <= 1'b0;
            rw_data_strobe_out <= 1'b0;
        end else if (start) begin
            rw_data_strobe_oe_out <= 1'b1; // [R20]
            rw_data_strobe_out <= 1'b1; // [R20]
        end else if (hdr_done) begin
            rw_data_strobe_oe_out <= next_hdr.dir; // [R1] [R11]
            rw_data_strobe_out <= 1'b0;
        end else if ((state == ddrc_pkg::ST_DATA) && hdr.dir && ck_edge) begin
            rw_data_strobe_out <= ck_rise; // [R11] [R14]
        end
    end

    // read bytes leave with the strobe edge that frames them
    always_ff @(posedge core_clk_in) begin
        if (reset_in || pins.cs_n) begin
            dq_oe_out <= 1'b0;
            dq_out <= 8'h00;
        end else if ((state == ddrc_pkg::ST_DATA) && hdr.dir && ck_edge) begin
            dq_oe_out <= 1'b1; // [R11]
            if (ck_rise) begin
                dq_out <= rd_word[15:8]; // [R14] [R15] [R17]
            end else begin
                dq_out <= rd_word[7:0]; // [R14] [R15] [R17]
            end
        end
    end

endmodule

/* File: ddrc_cmd_decode_props.sv */
`timescale 1ns/1ps

// ************
// link pin checks
// ************
module ddrc_cmd_decode_props (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic cs_n_in,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe_out,
    input wire logic rw_data_strobe_out,
    input wire logic rw_data_strobe_oe_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    // drive, strobe and selection relations
    a_data_strobe: assert property (dq_oe_out |-> rw_data_strobe_oe_out)
        else $error("data lanes driven without strobe");
    a_edge_align: assert property (
        dq_oe_out && $past(dq_oe_out) && $changed(dq_out) |-> $changed(rw_data_strobe_out))
        else $error("data byte moved without strobe edge");
    a_hdr_latency: assert property (
        $rose(rw_data_strobe_oe_out) |-> rw_data_strobe_out && !dq_oe_out)
        else $error("header strobe not high");
    a_sel_start: assert property (
        $rose(rw_data_strobe_oe_out) |-> !$past(cs_n_in) && !$past(cs_n_in, 2))
        else $error("strobe driven without selection");
    a_data_late: assert property ($rose(dq_oe_out) |-> $past(rw_data_strobe_oe_out, 8))
        else $error("read data before header and latency");
    a_whole_word: assert property ($fell(dq_oe_out) |-> !$past(rw_data_strobe_out))
        else $error("read ended after first byte");
    a_sel_release: assert property (
        cs_n_in [*5] |-> !dq_oe_out && !rw_data_strobe_oe_out)
        else $error("drive kept after deselect");
    a_strobe_hold: assert property (
        dq_oe_out && $changed(rw_data_strobe_out) |=> $stable(rw_data_strobe_out))
        else $error("strobe moved twice per edge");
endmodule

bind ddrc_cmd_decode ddrc_cmd_decode_props u_ddrc_cmd_decode_props (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .cs_n_in(cs_n_in),
    .dq_out(dq_out),
    .dq_oe_out(dq_oe_out),
    .rw_data_strobe_out(rw_data_strobe_out),
    .rw_data_strobe_oe_out(rw_data_strobe_oe_out)
);

/* File: ddrc_host_model.sv */
`timescale 1ns/1ps

// ************
// host side of the link
// ************
module ddrc_host_model (
    input wire logic core_clk_in,
    input wire logic [7:0] dev_dq_in,
    input wire logic dev_dq_oe_in,
    input wire logic dev_strobe_in,
    input wire logic dev_strobe_oe_in,
    output logic link_ck_out,
    output logic cs_n_out,
    output logic [7:0] dq_out,
    output logic strobe_out
);
    logic [7:0] drv_dq = 8'h00;
    logic drv_strobe = 1'b1;
    logic [15:0] wd [16];
    logic [15:0] rd [16];
    logic [31:0] rsb;

    // wire levels from both ends
    assign dq_out = dev_dq_oe_in ? dev_dq_in : drv_dq;
    assign strobe_out = dev_strobe_oe_in ? dev_strobe_in : drv_strobe;

    initial begin
        link_ck_out = 1'b0;
        cs_n_out = 1'b1;
    end

    // header, latency, then nb data edges
    task automatic frame(input logic [47:0] h, input int nb, input int lat);
        int n;
        int d;
        n = 6 + 4 * lat + nb;
        rsb = '0;
        @(posedge core_clk_in);
        cs_n_out <= 1'b0; // select while clock idle low
        for (int e = 0; e <= n; e++) begin
            d = e - 6 - 4 * lat;
            if (e < 6) drv_dq <= h[47 - 8 * e -: 8]; // msb byte first
            else if (d >= 0 && d < nb && !h[47]) drv_dq <= wd[d / 2][15 - 8 * (d % 2) -: 8];
            else drv_dq <= ~drv_dq; // released lanes wander
            drv_strobe <= (d >= 0 && !h[47]) ? 1'b0 : ~drv_strobe; // write mask off
            repeat (2) @(posedge core_clk_in);
            @(negedge core_clk_in);
            if (d > 0 && d <= nb && h[47]) begin
                rd[(d - 1) / 2][15 - 8 * ((d - 1) % 2) -: 8] = dev_dq_in;
                rsb[d - 1] = dev_strobe_in;
            end
            @(posedge core_clk_in);
            if (e < n) link_ck_out <= ~link_ck_out;
            @(posedge core_clk_in);
        end
        cs_n_out <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        link_ck_out <= 1'b0; // idle low before next selection
        repeat (4) @(posedge core_clk_in);
    endtask
endmodule

/* File: ddrc_params.svh */
`ifndef DDRC_PARAMS_SVH
`define DDRC_PARAMS_SVH

// ************************************************************
// link header timing
// ************************************************************
`define DDRC_ROWCAP_EDGE 3'h3
`define DDRC_HDR_LAST_EDGE 3'h5
`define DDRC_LAT_PAD 7'h02
`define DDRC_HALF_PAGE_MSB 2

// ************************************************************
// link register space
// ************************************************************
`define DDRC_LREG_ID 32'h0000_0000
`define DDRC_LREG_CFG 32'h0000_0001
`define DDRC_ID_VALUE 16'h0c5a
`define DDRC_CFG_RST 16'h0000

// ************************************************************
// bus register map
// ************************************************************
`define DDRC_IDX_CTRL 2'h0
`define DDRC_IDX_STATUS 2'h1
`define DDRC_IDX_ADDR 2'h2
`define DDRC_IDX_LINK 2'h3
`define DDRC_MAP_TOP 4
`define DDRC_CTRL_EN_BIT 0
`define DDRC_CTRL_LAT_LSB 4
`define DDRC_CTRL_LAT_MSB 7
`define DDRC_CTRL_RST 8'h61
`define DDRC_RESP_OKAY 2'h0
`define DDRC_RESP_SLVERR 2'h2

`endif

/* File: ddrc_pkg.sv */
package ddrc_pkg;

    // transaction phases on the link
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HDR,
        ST_LAT,
        ST_DATA
    } ddrc_state_e;

    // 48-bit command/address header, highest bit first
    typedef struct packed {
        logic dir;
        logic space_select_bit;
        logic burst_linear;
        logic [28:0] row_ucol;
        logic [12:0] rsvd;
        logic [2:0] lcol;
    } ddrc_hdr_s;

    // software control fields
    typedef struct packed {
        logic [3:0] lat_clks;
        logic enable;
    } ddrc_ctrl_s;

    // link pins sampled into the core clock
    typedef struct packed {
        logic ck;
        logic cs_n;
        logic strobe;
        logic [7:0] dq;
    } ddrc_pins_s;

endpackage

/* File: ddrc_sync.sv */
`timescale 1ns/1ps

// two-stage synchroniser for pins from outside the core clock
module ddrc_sync #(
    parameter int W = 11,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta;

    // first stage, read only by the second
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            meta <= RST_VAL;
        end else begin
            meta <= async_in;
        end
    end

    // second stage
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sync_out <= RST_VAL;
        end else begin
            sync_out <= meta;
        end
    end

endmodule
